// *** logic/pll_regs_pkg.sv ***
// Constants for the divider, calibration and readback register slice
package pll_regs_pkg;
  // Word format on the serial port
  localparam int WORD_BITS = 32;
  localparam int ADDR_MSB = 4;
  // Register addresses
  localparam logic [4:0] ADDR_LOOP_ONE_REF = 5'h1b;
  localparam logic [4:0] ADDR_LOOP_TWO_REF = 5'h1c;
  localparam logic [4:0] ADDR_OSC_CAL = 5'h1d;
  localparam logic [4:0] ADDR_LOOP_TWO_FB = 5'h1e;
  localparam logic [4:0] ADDR_READBACK = 5'h1f;
  localparam logic [4:0] ADDR_STATUS_ECHO = 5'h0c;
  localparam logic [4:0] ADDR_RSVD_A = 5'h09;
  localparam logic [4:0] ADDR_RSVD_LO = 5'h11;
  localparam logic [4:0] ADDR_RSVD_HI = 5'h17;
  // Field positions, low bit of each field
  localparam int FIRST_REF_LSB = 6;
  localparam int PUMP_FLOAT_BIT = 5;
  localparam int SECOND_REF_LSB = 20;
  localparam int FIRST_FB_LSB = 6;
  localparam int OSC_RANGE_LSB = 24;
  localparam int FAST_DET_BIT = 23;
  localparam int CAL_DIV_LSB = 5;
  localparam int PRESCALER_LSB = 24;
  localparam int SECOND_FB_LSB = 5;
  localparam int RB_LEVEL_BIT = 21;
  localparam int RB_ADDR_LSB = 16;
  localparam int LOCK_BIT = 5;
  // Field widths
  localparam int FIRST_REF_W = 14;
  localparam int SECOND_REF_W = 12;
  localparam int FIRST_FB_W = 14;
  localparam int OSC_RANGE_W = 3;
  localparam int CAL_DIV_W = 18;
  localparam int PRESCALER_W = 3;
  localparam int SECOND_FB_W = 18;
  localparam int RB_ADDR_W = 5;
  // Reset values
  localparam logic [13:0] FIRST_REF_RST = 14'h0001;
  localparam logic [11:0] SECOND_REF_RST = 12'h001;
  localparam logic [13:0] FIRST_FB_RST = 14'h0001;
  localparam logic [2:0] OSC_RANGE_RST = 3'h0;
  localparam logic [17:0] CAL_DIV_RST = 18'h0_0002;
  localparam logic [2:0] PRESCALER_RST = 3'h2;
  localparam logic [17:0] SECOND_FB_RST = 18'h0_0002;
  localparam logic [4:0] RB_ADDR_RST = 5'h00;
  // Oscillator input range codes
  localparam logic [2:0] OSC_RANGE_RSVD = 3'h3;
  localparam logic [2:0] OSC_RANGE_MAX = 3'h4;
  // Prescaler special codes
  localparam logic [2:0] PRESCALER_EIGHT = 3'h0;
  localparam logic [3:0] RATIO_EIGHT = 4'h8;
  localparam logic [3:0] RATIO_TWO = 4'h2;
  // Calibration run length
  localparam int CAL_TIME_US = 20;
  localparam int SYS_CLK_MHZ = 50;
  localparam int CAL_CYCLES = CAL_TIME_US * SYS_CLK_MHZ;
  // Calibration states
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN = 2'b01,
    CAL_DONE = 2'b11
  } cal_state_t;
endpackage : pll_regs_pkg

// *** logic/pll_divider_readback_regs.sv ***
// Divider, calibration and readback register slice behind a three-wire serial port
// How it works
// - Hold 14-bit first loop reference divider
// - Float bit tristates first loop pump
// - Hold 12-bit second loop reference divider
// - Hold first loop feedback divider, zero invalid
// - Oscillator range code for calibration
// - Calibration divider replaces feedback during calibration
// - Calibration divider only with internal oscillator
// - Feedback register write starts calibration in internal oscillator mode
// - Each calibration also raises sync event
// - Prescaler code zero eight, one two two
// - Hold 18-bit second loop feedback divider
// - Latch level bit selects readback pin level
// - Readback address selects returned register
// - Register twelve echoes readback address
// - Lock blocks writes to registers 0-30
// - Readback works whatever the lock
`timescale 1ns/10ps
`default_nettype none
module pll_divider_readback_regs #(
  parameter int CAL_CYCLES = pll_regs_pkg::CAL_CYCLES
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Serial programming link
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic serialLatchEnablePin,
  output logic readbackData,
  // Mode from the oscillator mux, 1 selects the internal oscillator
  input wire logic oscillatorSourceSelect,
  // Divider settings toward the loops
  output logic [13:0] firstLoopRefDivider,
  output logic firstLoopPumpFloat,
  output logic firstLoopPumpOutputEnable,
  output logic [11:0] secondLoopRefDivider,
  output logic [13:0] firstLoopFbDivider,
  output logic [2:0] oscInputRange,
  output logic fastDetectorSelect,
  output logic [17:0] calibrationDivider,
  output logic [3:0] secondLoopPrescaler,
  output logic [17:0] secondLoopFbDivider,
  output logic [17:0] activeFbDivider,
  // Readback and lock state
  output logic readbackLatchLevel,
  output logic [4:0] readbackAddress,
  output logic writeProtectLock,
  output logic readbackActive,
  // Calibration and status
  output logic calibrationActive,
  output logic syncEvent,
  output logic codeError
);

  // Ratio of the prescaler for a given code
  function automatic logic [3:0] prescaleRatio(input logic [2:0] code);
    if (code == pll_regs_pkg::PRESCALER_EIGHT) begin
      prescaleRatio = pll_regs_pkg::RATIO_EIGHT;
    end else if (code < 3'h3) begin
      prescaleRatio = pll_regs_pkg::RATIO_TWO;
    end else begin
      prescaleRatio = {1'b0, code};
    end
  endfunction : prescaleRatio

  // Link domain: reset copy, shift register, bit position
  logic [1:0] linkReset; // Resetn carried into the link domain
  logic [31:0] shiftWord; // Bits as they arrive, MSB first
  logic [4:0] bitCount; // Position within the 32-bit frame
  logic [31:0] readbackWord; // Word chosen for readback, sys domain

  // Reset crossing into the link clock
  always_ff @(posedge serialClk) begin
    linkReset <= {linkReset[0], resetn};
  end

  // Shift in on each rising link edge; frame is idle once the clock stops
  always_ff @(posedge serialClk) begin
    shiftWord <= {shiftWord[30:0], serialData};
  end

  // Bit counter wraps every 32 bits, keeping frames aligned
  always_ff @(posedge serialClk) begin
    if (!linkReset[1]) begin
      bitCount <= 5'h00;
    end else begin
      bitCount <= bitCount + 5'h01;
    end
  end

  // Readback bit; the chosen word only moves at a latch, so it is still mid-frame
  always_ff @(posedge serialClk) begin
    if (!linkReset[1]) begin
      readbackData <= 1'b0;
    end else begin
      readbackData <= readbackWord[5'd31 - bitCount];
    end
  end

  // Sys domain: latch pin synchroniser and edge
  logic [1:0] leSync; // Two-flop synchroniser, bit 0 only feeds bit 1
  logic lePrev; // Previous synchronised level
  logic latchPulse; // One cycle at a rising latch edge
  logic [4:0] wordAddr; // Address of the latched word
  logic writeAllowed; // Lock lets this write through

  // Latch enable pin enters the system clock
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      leSync <= 2'b00;
      lePrev <= 1'b0;
    end else begin
      leSync <= {leSync[0], serialLatchEnablePin};
      lePrev <= leSync[1];
    end
  end

  // The link clock is stopped before the latch rises, so shiftWord is steady here
  assign latchPulse = leSync[1] & ~lePrev;
  assign wordAddr = shiftWord[pll_regs_pkg::ADDR_MSB:0];
  assign writeAllowed = latchPulse & (!writeProtectLock || wordAddr == pll_regs_pkg::ADDR_READBACK);

  // First loop reference divider and pump float
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      firstLoopRefDivider <= pll_regs_pkg::FIRST_REF_RST;
      firstLoopPumpFloat <= 1'b0;
    end else if (writeAllowed && wordAddr == pll_regs_pkg::ADDR_LOOP_ONE_REF) begin
      firstLoopRefDivider <= shiftWord[pll_regs_pkg::FIRST_REF_LSB +: pll_regs_pkg::FIRST_REF_W];
      firstLoopPumpFloat <= shiftWord[pll_regs_pkg::PUMP_FLOAT_BIT];
    end
  end

  // Pump driven only while the float bit is clear
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      firstLoopPumpOutputEnable <= 1'b1;
    end else begin
      firstLoopPumpOutputEnable <= ~firstLoopPumpFloat;
    end
  end

  // Second loop reference and first loop feedback
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      secondLoopRefDivider <= pll_regs_pkg::SECOND_REF_RST;
      firstLoopFbDivider <= pll_regs_pkg::FIRST_FB_RST;
    end else if (writeAllowed && wordAddr == pll_regs_pkg::ADDR_LOOP_TWO_REF) begin
      secondLoopRefDivider <= shiftWord[pll_regs_pkg::SECOND_REF_LSB +: pll_regs_pkg::SECOND_REF_W];
      firstLoopFbDivider <= shiftWord[pll_regs_pkg::FIRST_FB_LSB +: pll_regs_pkg::FIRST_FB_W];
    end
  end

  // Oscillator range, fast detector, calibration divider
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      oscInputRange <= pll_regs_pkg::OSC_RANGE_RST;
      fastDetectorSelect <= 1'b0;
      calibrationDivider <= pll_regs_pkg::CAL_DIV_RST;
    end else if (writeAllowed && wordAddr == pll_regs_pkg::ADDR_OSC_CAL) begin
      oscInputRange <= shiftWord[pll_regs_pkg::OSC_RANGE_LSB +: pll_regs_pkg::OSC_RANGE_W];
      fastDetectorSelect <= shiftWord[pll_regs_pkg::FAST_DET_BIT];
      calibrationDivider <= shiftWord[pll_regs_pkg::CAL_DIV_LSB +: pll_regs_pkg::CAL_DIV_W];
    end
  end

  // Prescaler code and second loop feedback divider
  logic [2:0] prescalerCode; // Raw prescaler code
  logic feedbackWrite; // Accepted write to the feedback register
  assign feedbackWrite = writeAllowed && wordAddr == pll_regs_pkg::ADDR_LOOP_TWO_FB;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prescalerCode <= pll_regs_pkg::PRESCALER_RST;
      secondLoopFbDivider <= pll_regs_pkg::SECOND_FB_RST;
    end else if (feedbackWrite) begin
      prescalerCode <= shiftWord[pll_regs_pkg::PRESCALER_LSB +: pll_regs_pkg::PRESCALER_W];
      secondLoopFbDivider <= shiftWord[pll_regs_pkg::SECOND_FB_LSB +: pll_regs_pkg::SECOND_FB_W];
    end
  end

  // Decoded prescaler ratio
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      secondLoopPrescaler <= pll_regs_pkg::RATIO_TWO;
    end else begin
      secondLoopPrescaler <= prescaleRatio(prescalerCode);
    end
  end

  // Readback control and lock; register 31 stays writable even when locked
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      readbackLatchLevel <= 1'b0;
      readbackAddress <= pll_regs_pkg::RB_ADDR_RST;
      writeProtectLock <= 1'b0;
    end else if (writeAllowed && wordAddr == pll_regs_pkg::ADDR_READBACK) begin
      readbackLatchLevel <= shiftWord[pll_regs_pkg::RB_LEVEL_BIT];
      readbackAddress <= shiftWord[pll_regs_pkg::RB_ADDR_LSB +: pll_regs_pkg::RB_ADDR_W];
      writeProtectLock <= shiftWord[pll_regs_pkg::LOCK_BIT];
    end
  end

  // Readback window: pin at the selected level
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      readbackActive <= 1'b0;
    end else begin
      readbackActive <= (leSync[1] == readbackLatchLevel);
    end
  end

  // Readback word; reserved and unheld addresses return zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      readbackWord <= 32'h0000_0000;
    end else begin
      readbackWord <= 32'h0000_0000;
      case (readbackAddress)
        pll_regs_pkg::ADDR_STATUS_ECHO: begin
          readbackWord[pll_regs_pkg::RB_ADDR_LSB +: pll_regs_pkg::RB_ADDR_W] <= readbackAddress;
          readbackWord[4:0] <= readbackAddress;
        end
        pll_regs_pkg::ADDR_LOOP_ONE_REF: begin
          readbackWord[pll_regs_pkg::FIRST_REF_LSB +: pll_regs_pkg::FIRST_REF_W] <= firstLoopRefDivider;
          readbackWord[pll_regs_pkg::PUMP_FLOAT_BIT] <= firstLoopPumpFloat;
          readbackWord[4:0] <= readbackAddress;
        end
        pll_regs_pkg::ADDR_LOOP_TWO_REF: begin
          readbackWord[pll_regs_pkg::SECOND_REF_LSB +: pll_regs_pkg::SECOND_REF_W] <= secondLoopRefDivider;
          readbackWord[pll_regs_pkg::FIRST_FB_LSB +: pll_regs_pkg::FIRST_FB_W] <= firstLoopFbDivider;
          readbackWord[4:0] <= readbackAddress;
        end
        pll_regs_pkg::ADDR_OSC_CAL: begin
          readbackWord[pll_regs_pkg::OSC_RANGE_LSB +: pll_regs_pkg::OSC_RANGE_W] <= oscInputRange;
          readbackWord[pll_regs_pkg::FAST_DET_BIT] <= fastDetectorSelect;
          readbackWord[pll_regs_pkg::CAL_DIV_LSB +: pll_regs_pkg::CAL_DIV_W] <= calibrationDivider;
          readbackWord[4:0] <= readbackAddress;
        end
        pll_regs_pkg::ADDR_LOOP_TWO_FB: begin
          readbackWord[pll_regs_pkg::PRESCALER_LSB +: pll_regs_pkg::PRESCALER_W] <= prescalerCode;
          readbackWord[pll_regs_pkg::SECOND_FB_LSB +: pll_regs_pkg::SECOND_FB_W] <= secondLoopFbDivider;
          readbackWord[4:0] <= readbackAddress;
        end
        pll_regs_pkg::ADDR_READBACK: begin
          readbackWord[pll_regs_pkg::RB_LEVEL_BIT] <= readbackLatchLevel;
          readbackWord[pll_regs_pkg::RB_ADDR_LSB +: pll_regs_pkg::RB_ADDR_W] <= readbackAddress;
          readbackWord[pll_regs_pkg::LOCK_BIT] <= writeProtectLock;
          readbackWord[4:0] <= readbackAddress;
        end
        default: begin
          readbackWord <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Calibration sequencer; a new feedback write in internal mode restarts the run
  pll_regs_pkg::cal_state_t calState; // Current calibration state
  logic [31:0] calCount; // Cycles left in the run
  logic calStart; // Feedback write in internal mode
  assign calStart = feedbackWrite & oscillatorSourceSelect;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      calState <= pll_regs_pkg::CAL_IDLE;
      calCount <= 32'h0000_0000;
    end else if (calStart) begin
      calState <= pll_regs_pkg::CAL_RUN;
      calCount <= 32'(CAL_CYCLES);
    end else begin
      case (calState)
        pll_regs_pkg::CAL_RUN: begin
          calCount <= calCount - 32'h0000_0001;
          if (calCount == 32'h0000_0001) begin
            calState <= pll_regs_pkg::CAL_DONE;
          end
        end
        pll_regs_pkg::CAL_DONE: begin
          calState <= pll_regs_pkg::CAL_IDLE;
        end
        default: begin
          calState <= pll_regs_pkg::CAL_IDLE;
        end
      endcase
    end
  end

  // Calibration flags, sync pulse and active divider
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      calibrationActive <= 1'b0;
      syncEvent <= 1'b0;
      activeFbDivider <= pll_regs_pkg::SECOND_FB_RST;
    end else begin
      calibrationActive <= (calState == pll_regs_pkg::CAL_RUN);
      syncEvent <= calStart;
      activeFbDivider <= (calState == pll_regs_pkg::CAL_RUN && oscillatorSourceSelect)
                         ? calibrationDivider : secondLoopFbDivider;
    end
  end

  // Invalid codes flagged for software
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      codeError <= 1'b0;
    end else begin
      codeError <= (firstLoopRefDivider == 14'h0000) || (secondLoopRefDivider == 12'h000)
        || (firstLoopFbDivider == 14'h0000) || (oscInputRange == pll_regs_pkg::OSC_RANGE_RSVD)
        || (oscInputRange > pll_regs_pkg::OSC_RANGE_MAX) || (secondLoopFbDivider == 18'h0_0000)
        || (oscillatorSourceSelect && (calibrationDivider < 18'h0_0002
        || secondLoopFbDivider == 18'h0_0001));
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_fbWrite; feedbackWrite && oscillatorSourceSelect; endsequence
  sequence s_calRun; calibrationActive [*2]; endsequence
  a_cal_start: assert property (s_fbWrite |-> ##2 s_calRun)
    else $error("calibration did not start after feedback write");
  a_sync_pulse: assert property (s_fbWrite |=> syncEvent)
    else $error("no sync event at calibration start");
  a_ext_nocal: assert property (feedbackWrite && !oscillatorSourceSelect && calState == pll_regs_pkg::CAL_IDLE |=> ##1 !calibrationActive)
    else $error("calibration ran with external oscillator");
  a_cal_divider: assert property (calState == pll_regs_pkg::CAL_RUN && oscillatorSourceSelect && $stable(calibrationDivider) |=> activeFbDivider == $past(calibrationDivider))
    else $error("calibration divider not used during calibration");
  a_lock_blocks: assert property (latchPulse && writeProtectLock && wordAddr == pll_regs_pkg::ADDR_LOOP_ONE_REF |=> $stable(firstLoopRefDivider))
    else $error("locked register changed");
  a_lock_clear: assert property (latchPulse && wordAddr == pll_regs_pkg::ADDR_READBACK |=> writeProtectLock == $past(shiftWord[pll_regs_pkg::LOCK_BIT]))
    else $error("lock bit not writable");
  a_pump_float: assert property (firstLoopPumpFloat |=> !firstLoopPumpOutputEnable)
    else $error("pump driven while float set");
  a_prescale_eight: assert property (prescalerCode == pll_regs_pkg::PRESCALER_EIGHT |=> secondLoopPrescaler == pll_regs_pkg::RATIO_EIGHT)
    else $error("prescaler code zero not eight");
  a_echo_addr: assert property (readbackAddress == pll_regs_pkg::ADDR_STATUS_ECHO |=> readbackWord[20:16] == pll_regs_pkg::ADDR_STATUS_ECHO)
    else $error("register twelve does not echo address");
  a_rsvd_zero: assert property (readbackAddress == pll_regs_pkg::ADDR_RSVD_A |=> readbackWord == 32'h0000_0000)
    else $error("reserved address returned data");
  a_ref_write: assert property (writeAllowed && wordAddr == pll_regs_pkg::ADDR_LOOP_ONE_REF |=> firstLoopRefDivider == $past(shiftWord[19:6]))
    else $error("reference divider not stored");

endmodule : pll_divider_readback_regs
`default_nettype wire

// *** verif/serial_host_model.sv ***
// Host model that drives the three-wire serial programming link
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
  // Link toward the device
  output logic serialClk,
  output logic serialData,
  output logic serialLatchEnablePin
);
  // Link idles with its clock stopped and the latch low
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    serialLatchEnablePin = 1'b0;
  end
  // Bare pulses, only while the link side is held in reset
  task automatic pulse(input int n);
    repeat (n) begin
      #6 serialClk = 1'b1;
      #6 serialClk = 1'b0;
    end
  endtask : pulse
  // Whole 32-bit frame, MSB first; idle stretches the gap to act as a slow host
  task automatic send_frame(input logic [31:0] word, input int idle);
    for (int k = 31; k >= 0; k--) begin
      // Data moves while the clock is low, ahead of the sampling rise
      serialData = word[k];
      #6 serialClk = 1'b1;
      #6 serialClk = 1'b0;
    end
    // Released line shows the inverse so a stale bit never looks valid
    serialData = ~word[0];
    // Latch only after the clock has stopped, and hold it long enough to sync
    #20 serialLatchEnablePin = 1'b1;
    #130 serialLatchEnablePin = 1'b0;
    // Latch-low gap before the next frame
    #(80 + idle);
  endtask : send_frame
endmodule : serial_host_model
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the divider and readback register slice
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // Held field bits of registers 0x1b to 0x1f
  localparam logic [31:0] FMASK [0:4] = '{32'h000f_ffe0, 32'hffff_ffc0, 32'h07ff_ffe0,
                                          32'h077f_ffe0, 32'h003f_0020};
  // Readback addresses swept, reserved ones included
  localparam logic [4:0] RB_LIST [0:9] = '{5'h0c, 5'h09, 5'h11, 5'h17, 5'h1b, 5'h1c, 5'h1d,
                                           5'h1e, 5'h1f, 5'h00};
  // Clocks, reset and mode input
  logic sys_clk;
  logic resetn;
  logic oscillatorSourceSelect;
  // Link wires from the host model
  wire logic serialClk;
  wire logic serialData;
  wire logic serialLatchEnablePin;
  // Design outputs
  logic readbackData, firstLoopPumpFloat, firstLoopPumpOutputEnable, fastDetectorSelect;
  logic [13:0] firstLoopRefDivider, firstLoopFbDivider;
  logic [11:0] secondLoopRefDivider;
  logic [2:0] oscInputRange;
  logic [17:0] calibrationDivider, secondLoopFbDivider, activeFbDivider;
  logic [3:0] secondLoopPrescaler;
  logic readbackLatchLevel, writeProtectLock, readbackActive, calibrationActive;
  logic syncEvent, codeError;
  logic [4:0] readbackAddress;
  // Expected register images, notes for the monitor and counters
  logic [31:0] regImage [0:4] = '{32'h0000_0040, 32'h0010_0040, 32'h0000_0040, 32'h0200_0040,
                                  32'h0000_0000};
  logic [117:0] snapQueue [$];
  logic [63:0] readbackQueue [$];
  logic expectCal = 1'b0;
  logic [31:0] readbackShift;
  logic [31:0] seed = 32'h0000_ae6b;
  logic [3:0] syncCount = 4'h0;
  int numErrors = 0;
  int checkCount = 0;

  // Short calibration run keeps the bench quick
  pll_divider_readback_regs #(.CAL_CYCLES(8)) i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .serialClk(serialClk), .serialData(serialData),
    .serialLatchEnablePin(serialLatchEnablePin), .readbackData(readbackData),
    .oscillatorSourceSelect(oscillatorSourceSelect), .firstLoopRefDivider(firstLoopRefDivider),
    .firstLoopPumpFloat(firstLoopPumpFloat),
    .firstLoopPumpOutputEnable(firstLoopPumpOutputEnable),
    .secondLoopRefDivider(secondLoopRefDivider), .firstLoopFbDivider(firstLoopFbDivider),
    .oscInputRange(oscInputRange), .fastDetectorSelect(fastDetectorSelect),
    .calibrationDivider(calibrationDivider), .secondLoopPrescaler(secondLoopPrescaler),
    .secondLoopFbDivider(secondLoopFbDivider), .activeFbDivider(activeFbDivider),
    .readbackLatchLevel(readbackLatchLevel), .readbackAddress(readbackAddress),
    .writeProtectLock(writeProtectLock), .readbackActive(readbackActive),
    .calibrationActive(calibrationActive), .syncEvent(syncEvent), .codeError(codeError));
  // Far-side host
  serial_host_model i_host (
    .serialClk(serialClk), .serialData(serialData), .serialLatchEnablePin(serialLatchEnablePin));

  // 50 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Pseudo-random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction : lfsr
  // Word the device should shift out during the next frame
  function automatic logic [63:0] rb_exp();
    logic [4:0] a;
    a = regImage[4][20:16];
    if (a == 5'h0c) return {32'hffff_ffff, 11'h000, a, 11'h000, a};
    if (a < 5'h1b) return {32'hffff_ffff, 32'h0000_0000};
    // Upper bits of the lock register are don't-care on readback
    return {(a == 5'h1f) ? 32'h0000_003f : 32'hffff_ffff,
            (regImage[a - 5'h1b] & FMASK[a - 5'h1b]) | {27'h000_0000, a}};
  endfunction : rb_exp
  // Output picture expected once a frame has been latched
  function automatic logic [117:0] snap();
    logic [13:0] r1, n1;
    logic [11:0] r2;
    logic [2:0] o, p;
    logic [17:0] c, n2;
    logic [3:0] pr;
    logic e;
    r1 = regImage[0][19:6];
    r2 = regImage[1][31:20];
    n1 = regImage[1][19:6];
    o = regImage[2][26:24];
    c = regImage[2][22:5];
    p = regImage[3][26:24];
    n2 = regImage[3][22:5];
    pr = (p == 3'h0) ? 4'h8 : (p < 3'h3) ? 4'h2 : {1'b0, p};
    e = r1 == 14'h0000 || r2 == 12'h000 || n1 == 14'h0000 || o == 3'h3 || o > 3'h4 ||
        n2 == 18'h0_0000 || (n2 == 18'h0_0001 && oscillatorSourceSelect);
    return {r1, regImage[0][5], ~regImage[0][5], r2, n1, o, regImage[2][23], c, pr, n2,
            expectCal ? c : n2, regImage[4][21], regImage[4][20:16], regImage[4][5],
            regImage[4][21], expectCal, e, expectCal ? 4'h1 : 4'h0};
  endfunction : snap
  // Single comparison point
  task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Note expectations, then hand the frame to the host
  task automatic frame(input logic [31:0] w, input logic s, input int idle);
    logic ok;
    @(posedge sys_clk) #2 oscillatorSourceSelect = s;
    readbackQueue.push_back(rb_exp());
    // Lock freezes everything but the lock register itself
    ok = w[4:0] >= 5'h1b && (!regImage[4][5] || w[4:0] == 5'h1f);
    if (ok) regImage[w[4:0] - 5'h1b] = w;
    expectCal = ok && w[4:0] == 5'h1e && s;
    snapQueue.push_back(snap());
    i_host.send_frame(w, idle);
  endtask : frame
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  // Readback bits settle after each link rise
  always @(negedge serialClk) readbackShift <= {readbackShift[30:0], readbackData};
  // Sync pulses seen since the last frame
  always @(posedge sys_clk) if (syncEvent === 1'b1) syncCount <= syncCount + 4'h1;
  // Monitor: at the end of each latch pulse compare the oldest notes
  initial begin
    wait (resetn === 1'b1);
    forever begin
      @(negedge serialLatchEnablePin);
      check("outputs", {10'h000, firstLoopRefDivider, firstLoopPumpFloat, firstLoopPumpOutputEnable,
            secondLoopRefDivider, firstLoopFbDivider, oscInputRange, fastDetectorSelect,
            calibrationDivider, secondLoopPrescaler, secondLoopFbDivider, activeFbDivider,
            readbackLatchLevel, readbackAddress, writeProtectLock, readbackActive, calibrationActive,
            codeError, syncCount}, {10'h000, snapQueue.pop_front()});
      check("readback", {96'h0, readbackShift & readbackQueue[0][63:32]},
            {96'h0, readbackQueue[0][31:0] & readbackQueue[0][63:32]});
      void'(readbackQueue.pop_front());
      syncCount = 4'h0;
    end
  end
  // Watchdog against a hung run
  initial begin
    #100000;
    numErrors++;
    $display("watchdog expired");
    complete_run();
  end
  // Main sequence
  initial begin
    resetn = 1'b0;
    oscillatorSourceSelect = 1'b0;
    repeat (8) @(posedge sys_clk);
    // Link side needs clock edges to leave reset cleanly
    i_host.pulse(3);
    repeat (8) @(posedge sys_clk);
    #2 resetn = 1'b1;
    i_host.pulse(2);
    frame(32'h0000_0000, 1'b0, 0);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      // Calibration divider kept at two or more
      frame({seed[31:5], 5'h1b + 5'(i % 4)} | ((i % 4 == 2) ? 32'h0000_0040 : 32'h0)
            | ((i % 4 == 1) ? 32'h0020_0000 : 32'h0), seed[0], int'(seed[3:0]) * 20);
    end
    $display("random writes done");
    for (int i = 0; i < 8; i++) begin
      frame({5'h00, 3'(i), 1'b0, 18'h0_0010 + 18'(i), 5'h1e}, 1'b0, 0);
      if (i <= 4) frame({5'h00, 3'(i), 1'b0, 18'h0_0004, 5'h1d}, 1'b0, 0);
    end
    $display("code sweep done");
    // Calibration divider matched to the feedback value, slow detector
    frame({5'h00, 3'h0, 1'b0, 18'h0_0100, 5'h1d}, 1'b1, 0);
    // Back-to-back feedback writes each start a run and a sync
    frame({5'h00, 3'h3, 1'b0, 18'h0_0100, 5'h1e}, 1'b1, 0);
    frame({5'h00, 3'h4, 1'b0, 18'h0_0101, 5'h1e}, 1'b1, 0);
    $display("calibration done");
    frame({12'h000, 14'h0000, 1'b1, 5'h1b}, 1'b0, 0);
    frame({12'h000, 14'h3fff, 1'b0, 5'h1b}, 1'b0, 0);
    $display("divider limits done");
    frame({10'h000, 1'b0, 5'h1b, 10'h000, 1'b1, 5'h1f}, 1'b0, 0);
    frame({12'h000, 14'h0123, 1'b1, 5'h1b}, 1'b0, 0);
    frame({5'h00, 3'h5, 1'b0, 18'h0_0200, 5'h1e}, 1'b1, 0);
    frame({10'h000, 1'b0, 5'h1b, 10'h000, 1'b0, 5'h1f}, 1'b0, 0);
    frame({12'h000, 14'h0123, 1'b1, 5'h1b}, 1'b0, 0);
    $display("write lock done");
    for (int i = 0; i < 10; i++) begin
      frame({10'h000, 1'(i), RB_LIST[i], 10'h000, 1'b0, 5'h1f}, 1'b0, 0);
    end
    // Unmapped address: refused, still returns the selected word
    frame(32'h0000_0005, 1'b0, 0);
    $display("readback sweep done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
